// [hw/hcr_device.sv]
// Device end: host command word, maintenance interrupt, soft reset, FIFO test steering.
// Assumes core logic answers busy/done strobes on sys_clk.
`timescale 1ns/1ns
module hcr_device #(
  parameter int START_CYC = hcr_pkg::START_DONE_CYC
) (
  // Clock and reset
  input  wire logic        sys_clk,
  input  wire logic        rst_n,
  // Processor bus
  hcr_if.dev               bus,
  // Core events
  input  wire logic        maint_cell_rx,
  input  wire logic        maint_crc_ok,
  input  wire logic        tx_backpressure,
  input  wire logic        maint_sent,
  // Core controls
  output logic             core_hold_rst,
  output logic             queues_underrun,
  output logic             fifo_test_access,
  output logic [1:0]       fifo_sel,
  output logic [6:0]       fifo_wr_addr,
  output logic [6:0]       fifo_rd_addr,
  output logic             maint_send_req,
  output logic             maint_send_buf,
  output logic             rescan_active,
  output logic [15:0]      maint_status_word,
  output logic [7:0]       maint_wr_slot
);
  // ****************************************
  // Command word state
  // ****************************************
  logic        mask_q, send0_q, send1_q, rescan_q, start_q, soft_q, test_q, latch_q;
  logic        irq_n_q, rvalid_q, send_busy_q, send_buf_q;
  logic [15:0] rdata_q;
  logic [31:0] start_cnt_q;
  logic [3:0]  rescan_cnt_q;
  logic [7:0]  slot_q;
  logic [15:0] stat_q;
  logic        hit_w, wr_cmd, rd_cmd, core_rst;
  logic [15:0] cmd_view;
  logic        start_done, rescan_done, send_take;

  assign hit_w      = bus.addr == hcr_pkg::CMD_WORD_ADDR;
  assign wr_cmd     = bus.wr & hit_w & ~test_q;
  assign rd_cmd     = bus.rd & hit_w & ~test_q;
  assign core_rst   = ~rst_n | soft_q;
  assign start_done = start_q & ~tx_backpressure & (start_cnt_q == 32'd0);
  assign rescan_done = rescan_q & (rescan_cnt_q == 4'd0);
  assign send_take  = ~send_busy_q & (send0_q | send1_q) & ~core_rst;
  assign cmd_view   = {8'h00, test_q, latch_q, soft_q, start_q, rescan_q, send1_q, send0_q, mask_q};

  // ****************************************
  // Control bits
  // ****************************************
  always_ff @(posedge sys_clk)
  begin
    if (!rst_n)
    begin
      {test_q, latch_q, soft_q, start_q, rescan_q, send1_q, send0_q, mask_q} <= hcr_pkg::CMD_RESET_VAL[7:0];
    end
    else
    begin
      if (wr_cmd)
      begin
        mask_q <= bus.wdata[hcr_pkg::BIT_MASK];
        soft_q <= bus.wdata[hcr_pkg::BIT_SOFT_RST];
      end
      test_q <= (bus.wr & hit_w) ? bus.wdata[hcr_pkg::BIT_FIFO_TEST] : test_q;
      // Set wins over clear so a cell in the clear cycle is kept
      if (maint_cell_rx & ~soft_q)
        latch_q <= 1'b1;
      else if (wr_cmd & bus.wdata[hcr_pkg::BIT_CLR_LATCH])
        latch_q <= 1'b0;
      if (wr_cmd & bus.wdata[hcr_pkg::BIT_START])
        start_q <= 1'b1;
      else if (start_done | soft_q)
        start_q <= 1'b0;
      if (wr_cmd & bus.wdata[hcr_pkg::BIT_RESCAN])
        rescan_q <= 1'b1;
      else if (rescan_done | soft_q)
        rescan_q <= 1'b0;
      if (wr_cmd & bus.wdata[hcr_pkg::BIT_SEND0])
        send0_q <= 1'b1;
      else if ((send_busy_q & maint_sent & ~send_buf_q) | soft_q)
        send0_q <= 1'b0;
      if (wr_cmd & bus.wdata[hcr_pkg::BIT_SEND1])
        send1_q <= 1'b1;
      else if ((send_busy_q & maint_sent & send_buf_q) | soft_q)
        send1_q <= 1'b0;
    end
  end

  // ****************************************
  // Sequencers
  // ****************************************
  always_ff @(posedge sys_clk)
  begin
    if (core_rst)
    begin
      send_busy_q  <= 1'b0;
      send_buf_q   <= 1'b0;
      start_cnt_q  <= 32'd0;
      rescan_cnt_q <= 4'd0;
    end
    else
    begin
      if (send_take)
      begin
        send_busy_q <= 1'b1;
        send_buf_q  <= ~send0_q;
      end
      else if (maint_sent)
        send_busy_q <= 1'b0;
      // Cell building stalls under backpressure, so the count waits too
      if (wr_cmd & bus.wdata[hcr_pkg::BIT_START])
        start_cnt_q <= START_CYC[31:0] - 32'd1;
      else if (start_q & ~tx_backpressure & (start_cnt_q != 32'd0))
        start_cnt_q <= start_cnt_q - 32'd1;
      // Revision, summary, then eight line mode words
      if (wr_cmd & bus.wdata[hcr_pkg::BIT_RESCAN])
        rescan_cnt_q <= 4'(hcr_pkg::RESCAN_WORDS - 1);
      else if (rescan_cnt_q != 4'd0)
        rescan_cnt_q <= rescan_cnt_q - 4'd1;
    end
  end

  // ****************************************
  // Maintenance queue write slot and status
  // ****************************************
  always_ff @(posedge sys_clk)
  begin
    if (core_rst)
    begin
      slot_q <= 8'h00;
      stat_q <= 16'h0000;
    end
    else if (maint_cell_rx)
    begin
      slot_q <= slot_q + 8'h01;
      stat_q <= {maint_crc_ok, 15'h0000};
    end
  end

  // ****************************************
  // Bus answer and outputs
  // ****************************************
  always_ff @(posedge sys_clk)
  begin
    if (!rst_n)
    begin
      rdata_q  <= 16'h0000;
      rvalid_q <= 1'b0;
      irq_n_q  <= 1'b1;
    end
    else
    begin
      rvalid_q <= bus.rd;
      rdata_q  <= rd_cmd ? cmd_view : 16'h0000;
      irq_n_q  <= ~(latch_q & ~mask_q);
    end
  end

  always_ff @(posedge sys_clk)
  begin
    if (!rst_n)
    begin
      core_hold_rst   <= 1'b1;
      queues_underrun <= 1'b1;
      fifo_test_access <= 1'b0;
      fifo_sel        <= hcr_pkg::FSEL_NONE;
      fifo_wr_addr    <= 7'h00;
      fifo_rd_addr    <= 7'h00;
      maint_send_req  <= 1'b0;
      maint_send_buf  <= 1'b0;
      rescan_active   <= 1'b0;
      maint_status_word <= 16'h0000;
      maint_wr_slot   <= 8'h00;
    end
    else
    begin
      core_hold_rst   <= soft_q;
      queues_underrun <= soft_q ? 1'b1 : (queues_underrun & ~maint_cell_rx);
      fifo_test_access <= test_q;
      fifo_sel        <= test_q ? bus.addr[15:14] : hcr_pkg::FSEL_NONE;
      fifo_wr_addr    <= bus.addr[6:0];
      fifo_rd_addr    <= bus.addr[13:7];
      maint_send_req  <= send_busy_q;
      maint_send_buf  <= send_buf_q;
      rescan_active   <= rescan_q;
      maint_status_word <= stat_q;
      maint_wr_slot   <= slot_q;
    end
  end

  assign bus.rdata  = rdata_q;
  assign bus.rvalid = rvalid_q;
  assign bus.irq_n  = irq_n_q;
endmodule

// [hw/hcr_host.sv]
// Host end: writes and polls the command word on the processor bus.
// Assumes one command at a time from user side; playout address from helper.
`timescale 1ns/1ns
module hcr_host (
  // Clock and reset
  input  wire logic        sys_clk,
  input  wire logic        rst_n,
  // Processor bus
  hcr_if.host              bus,
  // User command
  input  wire logic        cmd_valid,
  input  wire logic [7:0]  cmd_bits,
  input  wire logic        pos_t1,
  input  wire logic [2:0]  pos_line,
  input  wire logic [4:0]  pos_mf,
  input  wire logic [4:0]  pos_frame,
  input  wire logic [4:0]  pos_chan,
  input  wire logic        pos_uns,
  // Status
  output logic             cmd_ready,
  output logic             cmd_done,
  output logic             irq_seen,
  output logic [17:0]      pos_addr,
  output logic             pos_upper,
  output logic             pos_used
);
  hcr_pkg::hcr_host_st_t st_q;
  logic [7:0]  bits_q;
  logic [17:0] addr_q, pa_w;
  logic        up_w, used_w;
  logic [15:0] wdata_q;
  logic        wr_q, rd_q, ready_q, done_q, irq_q;
  logic [7:0]  clean_w;
  logic [7:0]  wait_bits_w;

  hcr_playout_addr u_pa (
    .t1_mode      (pos_t1),
    .unstructured (pos_uns),
    .line         (pos_line),
    .multiframe   (pos_mf),
    .frame        (pos_frame),
    .channel      (pos_chan),
    .word_addr    (pa_w),
    .upper_byte   (up_w),
    .slot_used    (used_w)
  );

  // Start and rescan never together: rescan dropped
  assign clean_w = cmd_bits[hcr_pkg::BIT_START] ? (cmd_bits & 8'hf7) : cmd_bits;
  // Self-clearing bits polled until zero
  assign wait_bits_w = bits_q & 8'h1e;

  always_ff @(posedge sys_clk)
  begin
    if (!rst_n)
    begin
      st_q    <= hcr_pkg::HCR_ST_IDLE;
      bits_q  <= 8'h00;
      addr_q  <= 18'h00000;
      wdata_q <= 16'h0000;
      wr_q    <= 1'b0;
      rd_q    <= 1'b0;
      ready_q <= 1'b0;
      done_q  <= 1'b0;
      irq_q   <= 1'b0;
    end
    else
    begin
      wr_q   <= 1'b0;
      rd_q   <= 1'b0;
      done_q <= 1'b0;
      irq_q  <= ~bus.irq_n;
      addr_q <= hcr_pkg::CMD_WORD_ADDR;
      unique case (st_q)
        hcr_pkg::HCR_ST_IDLE:
        begin
          ready_q <= 1'b1;
          if (cmd_valid & ready_q)
          begin
            bits_q  <= clean_w;
            wdata_q <= {8'h00, clean_w};
            wr_q    <= 1'b1;
            ready_q <= 1'b0;
            st_q    <= hcr_pkg::HCR_ST_WR;
          end
        end
        hcr_pkg::HCR_ST_WR:
        begin
          rd_q <= 1'b1;
          st_q <= hcr_pkg::HCR_ST_WAIT;
        end
        hcr_pkg::HCR_ST_WAIT:
        begin
          if (bus.rvalid)
          begin
            if ((bus.rdata[7:0] & wait_bits_w) == 8'h00)
            begin
              done_q <= 1'b1;
              st_q   <= hcr_pkg::HCR_ST_IDLE;
            end
            else
              rd_q <= 1'b1;
          end
        end
      endcase
    end
  end

  always_ff @(posedge sys_clk)
  begin
    if (!rst_n)
    begin
      pos_addr  <= 18'h00000;
      pos_upper <= 1'b0;
      pos_used  <= 1'b0;
    end
    else
    begin
      pos_addr  <= pa_w;
      pos_upper <= up_w;
      pos_used  <= used_w;
    end
  end

  assign bus.addr  = addr_q;
  assign bus.wdata = wdata_q;
  assign bus.wr    = wr_q;
  assign bus.rd    = rd_q;
  assign cmd_ready = ready_q;
  assign cmd_done  = done_q;
  assign irq_seen  = irq_q;
endmodule

// [hw/hcr_playout_addr.sv]
// Playout buffer word address and byte lane from line, multiframe, frame, channel.
// Assumes inputs already in range for the selected structure.
`timescale 1ns/1ns
module hcr_playout_addr (
  // Position
  input  wire logic       t1_mode,
  input  wire logic       unstructured,
  input  wire logic [2:0] line,
  input  wire logic [4:0] multiframe,
  input  wire logic [4:0] frame,
  input  wire logic [4:0] channel,
  // Result
  output logic [17:0]     word_addr,
  output logic            upper_byte,
  output logic            slot_used
);
  logic [17:0] mf_part;
  logic [17:0] base_part;
  // Line * 8192 + mf * 256|512 + frame * 16 + chan/2
  assign mf_part    = t1_mode ? {4'h0, multiframe[3:0], 9'h000, 1'b0} >> 1 : {5'h00, multiframe, 8'h00};
  // Address rises with play-out time, so writes land in play-out order
  assign base_part  = {2'h0, line, 13'h0000} + mf_part + {9'h000, frame, 4'h0} + {14'h0000, channel[4:1]};
  assign word_addr  = hcr_pkg::PLAYOUT_BASE + base_part;
  assign upper_byte = channel[0];
  // T1 structured keeps 24 bytes of 24 frames per 32; unstructured uses all
  assign slot_used  = unstructured | ~t1_mode | ((channel < 5'd24) & (frame < 5'd24));
endmodule

// [inc/hcr_if.sv]
// Interface joining the processor-bus host and the command-word device.
// Assumes both ends on sys_clk; one access per strobe pulse.
`timescale 1ns/1ns
interface hcr_if;
  logic [17:0] addr;
  logic [15:0] wdata;
  logic        wr;
  logic        rd;
  logic [15:0] rdata;
  logic        rvalid;
  logic        irq_n;
  modport dev  (input addr, wdata, wr, rd, output rdata, rvalid, irq_n);
  modport host (output addr, wdata, wr, rd, input rdata, rvalid, irq_n);
endinterface

// [inc/hcr_pkg.sv]
// Package for the host command word block: offsets, field positions, resets, counts.
// Assumes one 100 MHz system clock shared by both ends.
package hcr_pkg;
  // ****************************************
  // Register map
  // ****************************************
  localparam logic [17:0] CMD_WORD_ADDR   = 18'h20000;
  localparam logic [17:0] PLAYOUT_BASE    = 18'h10000;
  localparam logic [17:0] MAINT_Q_BASE    = 18'h0e000;
  localparam logic [15:0] CMD_RESET_VAL   = 16'h0021;
  localparam int          BIT_MASK        = 0;
  localparam int          BIT_SEND0       = 1;
  localparam int          BIT_SEND1       = 2;
  localparam int          BIT_RESCAN      = 3;
  localparam int          BIT_START       = 4;
  localparam int          BIT_SOFT_RST    = 5;
  localparam int          BIT_CLR_LATCH   = 6;
  localparam int          BIT_FIFO_TEST   = 7;
  localparam int          CRC_PASS_BIT    = 15;
  localparam logic [4:0]  MAINT_WORDS     = 5'h1c;
  // ****************************************
  // Playout buffer geometry
  // ****************************************
  localparam int LINE_STRIDE  = 8192;
  localparam int E1_MF_STRIDE = 256;
  localparam int T1_MF_STRIDE = 512;
  localparam int FRAME_STRIDE = 16;
  localparam int FRAMES_PER_LINE = 512;
  localparam int BYTES_PER_FRAME = 32;
  localparam int T1_BYTES     = 24;
  localparam int T1_FRAMES    = 24;
  localparam int MAINT_CELLS  = 256;
  localparam int MAINT_SLOT_BYTES = 64;
  // ****************************************
  // FIFO test select codes
  // ****************************************
  localparam logic [1:0] FSEL_NONE = 2'h0;
  localparam logic [1:0] FSEL_SIG  = 2'h1;
  localparam logic [1:0] FSEL_RX   = 2'h2;
  localparam logic [1:0] FSEL_TX   = 2'h3;
  // ****************************************
  // Timing
  // ****************************************
  localparam int CLK_MHZ         = 100;
  localparam int START_DONE_MS   = 3;
  localparam int START_DONE_CYC  = START_DONE_MS * 1000 * 1000 * CLK_MHZ / 1000;
  localparam int RESCAN_WORDS    = 10;
  typedef enum logic [2:0] {
    HCR_ST_IDLE = 3'b001,
    HCR_ST_WR   = 3'b010,
    HCR_ST_WAIT = 3'b100
  } hcr_host_st_t;
endpackage

// [tb/hcr_chk.sv]
// Checker for the processor bus between the host and device ends.
// Assumes it sits beside the interface that joins hcr_host and hcr_device.
`timescale 1ns/1ns
module hcr_chk (
  // Clock and reset
  input wire logic        sys_clk,
  input wire logic        rst_n,
  // Bus
  input wire logic [17:0] addr,
  input wire logic [15:0] wdata,
  input wire logic        wr,
  input wire logic        rd,
  input wire logic [15:0] rdata,
  input wire logic        rvalid,
  input wire logic        irq_n
);
  // ****************************************
  // Shadow of the written command bits
  // ****************************************
  logic test_q;
  logic mask_q;
  logic soft_q;
  logic cmd_rd_q;
  wire  cmd_hit = (addr == hcr_pkg::CMD_WORD_ADDR);
  // In test mode a write only moves the test bit
  wire  take_wr = wr && cmd_hit && !test_q;

  always_ff @(posedge sys_clk)
  begin
    if (!rst_n)
    begin
      test_q   <= 1'b0;
      mask_q   <= 1'b1;
      soft_q   <= 1'b1;
      cmd_rd_q <= 1'b0;
    end
    else
    begin
      test_q   <= (wr && cmd_hit) ? wdata[7] : test_q;
      mask_q   <= take_wr ? wdata[0] : mask_q;
      soft_q   <= take_wr ? wdata[5] : soft_q;
      cmd_rd_q <= rd && cmd_hit && !test_q;
    end
  end

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);

  a_rvalid_follows: assert property (rd |=> rvalid)
    else $error("read got no data valid");
  a_rvalid_caused: assert property (rvalid |-> $past(rd))
    else $error("data valid without read");
  a_upper_zero: assert property (rvalid |-> rdata[15:8] == 8'h00)
    else $error("upper byte not zero");
  a_test_reads_zero: assert property (test_q && rd |=> rdata == 16'h0000)
    else $error("read in test mode not zero");
  a_read_tracks_bits: assert property (rvalid && cmd_rd_q |-> rdata[5] == $past(soft_q) && rdata[0] == $past(mask_q))
    else $error("command word read differs from written bits");
  a_mask_quiets_irq: assert property (mask_q [*2] |-> irq_n)
    else $error("interrupt while masked");
  a_irq_when_unmasked: assert property (!irq_n |-> !$past(mask_q))
    else $error("interrupt without clear mask");
  a_reset_quiet: assert property (disable iff (1'b0) !rst_n |=> irq_n && !rvalid)
    else $error("bus outputs active in reset");

  c_irq: cover property (!irq_n);
  c_test_read: cover property (test_q && rd);
  c_latch_read: cover property (rvalid && rdata[6]);
endmodule

// [tb/tb_host_command_and_rx_buffers.sv]
// Testbench: host and device ends joined, plus a second device driven by the bench.
// Assumes a 100 MHz clock and the start count shortened to 8 cycles.
`timescale 1ns/1ns
`define CHK(g, e) begin check_count++; if ((g) !== (e)) begin error_cnt++; $display("ERROR %0t got %h exp %h", $time, g, e); end end
module tb_host_command_and_rx_buffers;
  localparam logic [17:0] CMD = hcr_pkg::CMD_WORD_ADDR;
  logic sys_clk = 1'b0, rst_n = 1'b0, rx = 1'b0, crc = 1'b0, bp = 1'b0, sent = 1'b0;
  logic cmd_valid = 1'b0, t1 = 1'b0, uns = 1'b0;
  logic [7:0] cmd_bits = 8'h00;
  logic [2:0] line = 3'h0;
  logic [4:0] mf = 5'h00, frame = 5'h00, chan = 5'h00;
  logic cmd_ready, cmd_done, irq_seen, up, used, core_hold, underrun, fta, send_buf, send_req, rescan_on;
  logic [17:0] pos_addr;
  logic [1:0] fsel;
  logic [6:0] fwa, fra;
  logic [15:0] status;
  logic [7:0] slot;
  int error_cnt = 0;
  int check_count = 0;

  hcr_if bus_a ();
  hcr_if bus_b ();
  hcr_host hcr_host_i (.sys_clk(sys_clk), .rst_n(rst_n), .bus(bus_a.host), .cmd_valid(cmd_valid),
    .cmd_bits(cmd_bits), .pos_t1(t1), .pos_line(line), .pos_mf(mf), .pos_frame(frame), .pos_chan(chan),
    .pos_uns(uns), .cmd_ready(cmd_ready), .cmd_done(cmd_done), .irq_seen(irq_seen), .pos_addr(pos_addr),
    .pos_upper(up), .pos_used(used));
  hcr_device #(.START_CYC(8)) hcr_device_i (.sys_clk(sys_clk), .rst_n(rst_n), .bus(bus_a.dev),
    .maint_cell_rx(rx), .maint_crc_ok(crc), .tx_backpressure(bp), .maint_sent(sent), .core_hold_rst(),
    .queues_underrun(), .fifo_test_access(), .fifo_sel(), .fifo_wr_addr(), .fifo_rd_addr(),
    .maint_send_req(), .maint_send_buf(), .rescan_active(), .maint_status_word(), .maint_wr_slot());
  // Second device lets the bench reach unmapped and test-mode addresses
  hcr_device #(.START_CYC(8)) hcr_device_t_i (.sys_clk(sys_clk), .rst_n(rst_n), .bus(bus_b.dev),
    .maint_cell_rx(rx), .maint_crc_ok(crc), .tx_backpressure(bp), .maint_sent(sent),
    .core_hold_rst(core_hold), .queues_underrun(underrun), .fifo_test_access(fta), .fifo_sel(fsel),
    .fifo_wr_addr(fwa), .fifo_rd_addr(fra), .maint_send_req(send_req), .maint_send_buf(send_buf),
    .rescan_active(rescan_on), .maint_status_word(status), .maint_wr_slot(slot));
  hcr_chk hcr_chk_i (.sys_clk(sys_clk), .rst_n(rst_n), .addr(bus_a.addr), .wdata(bus_a.wdata),
    .wr(bus_a.wr), .rd(bus_a.rd), .rdata(bus_a.rdata), .rvalid(bus_a.rvalid), .irq_n(bus_a.irq_n));

  always #5 sys_clk = ~sys_clk;

  // ****************************************
  // Bus and helper tasks
  // ****************************************
  task automatic bw(input logic [17:0] a, input logic [15:0] d);
    @(negedge sys_clk);
    bus_b.addr = a;
    bus_b.wdata = d;
    bus_b.wr = 1'b1;
    @(negedge sys_clk);
    bus_b.wr = 1'b0;
  endtask
  task automatic br(input logic [17:0] a, input logic [15:0] e);
    @(negedge sys_clk);
    bus_b.addr = a;
    bus_b.rd = 1'b1;
    @(negedge sys_clk);
    bus_b.rd = 1'b0;
    `CHK(bus_b.rvalid, 1'b1)
    `CHK(bus_b.rdata, e)
  endtask
  task automatic pulse(ref logic s);
    @(negedge sys_clk);
    s = 1'b1;
    @(negedge sys_clk);
    s = 1'b0;
  endtask
  task automatic idle(input int n);
    repeat (n) @(negedge sys_clk);
  endtask
  task automatic hcmd(input logic [7:0] b);
    int n;
    n = 0;
    while (cmd_ready !== 1'b1 && n < 200) @(negedge sys_clk) n++;
    cmd_bits = b;
    cmd_valid = 1'b1;
    @(negedge sys_clk);
    cmd_valid = 1'b0;
    n = 0;
    while (cmd_done !== 1'b1 && n < 200) @(negedge sys_clk) n++;
    `CHK(cmd_done, 1'b1)
  endtask
  task automatic pcase(input logic a_t1, input logic a_uns, input int l, input int m, input int f, input int c);
    logic [17:0] e;
    t1 = a_t1;
    uns = a_uns;
    line = 3'(l);
    mf = 5'(m);
    frame = 5'(f);
    chan = 5'(c);
    e = 18'(hcr_pkg::PLAYOUT_BASE + l * 8192 + m * (a_t1 ? 512 : 256) + f * 16 + c / 2);
    idle(2);
    `CHK(3'((pos_addr - hcr_pkg::PLAYOUT_BASE) >> 13), 3'(l))
    `CHK(pos_addr, e)
    `CHK(up, 1'(c % 2))
    `CHK(used, (a_uns || !a_t1 || (f < 24 && c < 24)))
  endtask
  task automatic final_report;
    if (error_cnt == 0 && check_count > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  // ****************************************
  // Tests
  // ****************************************
  initial
  begin
    bus_b.addr = 18'h00000;
    bus_b.wdata = 16'h0000;
    bus_b.wr = 1'b0;
    bus_b.rd = 1'b0;
    idle(5);
    rst_n = 1'b1;
    br(CMD, 16'h0021);
    `CHK(core_hold, 1'b1)
    `CHK(underrun, 1'b1)
    br(18'h00000, 16'h0000);
    bw(CMD, 16'h0002);
    br(CMD, 16'h0002);
    `CHK(core_hold, 1'b0)
    `CHK(send_req, 1'b1)
    pulse(sent);
    br(CMD, 16'h0000);
    `CHK(send_req, 1'b0)
    bw(CMD, 16'h0006);
    idle(3);
    `CHK(send_buf, 1'b0)
    pulse(sent);
    idle(3);
    `CHK(send_buf, 1'b1)
    br(CMD, 16'h0004);
    pulse(sent);
    br(CMD, 16'h0000);
    crc = 1'b1;
    pulse(rx);
    idle(2);
    br(CMD, 16'h0040);
    `CHK(bus_b.irq_n, 1'b0)
    `CHK(status, 16'h8000)
    `CHK(underrun, 1'b0)
    bw(CMD, 16'h0040);
    idle(2);
    `CHK(bus_b.irq_n, 1'b1)
    br(CMD, 16'h0000);
    bw(CMD, 16'h0001);
    crc = 1'b0;
    pulse(rx);
    idle(2);
    `CHK(bus_b.irq_n, 1'b1)
    `CHK(status, 16'h0000)
    `CHK(slot, 8'h02)
    bw(CMD, 16'h0000);
    idle(2);
    `CHK(bus_b.irq_n, 1'b0)
    bw(CMD, 16'h0040);
    bw(CMD, 16'h0008);
    br(CMD, 16'h0008);
    `CHK(rescan_on, 1'b1)
    idle(12);
    br(CMD, 16'h0000);
    `CHK(rescan_on, 1'b0)
    bp = 1'b1;
    bw(CMD, 16'h0010);
    idle(20);
    br(CMD, 16'h0010);
    bp = 1'b0;
    idle(12);
    br(CMD, 16'h0000);
    bw(CMD, 16'h0020);
    idle(1);
    `CHK(core_hold, 1'b1)
    `CHK(underrun, 1'b1)
    bw(CMD, 16'h0080);
    for (int s = 1; s < 4; s++)
    begin
      br({2'b00, 2'(s), 7'h55, 7'h2a}, 16'h0000);
      `CHK(fta, 1'b1)
      `CHK(fsel, 2'(s))
      `CHK(fwa, 7'h2a)
      `CHK(fra, 7'h55)
    end
    bw(CMD, 16'h0000);
    br(CMD, 16'h0000);
    pcase(1'b1, 1'b0, 3, 5, 7, 9);
    pcase(1'b1, 1'b0, 1, 2, 24, 3);
    pcase(1'b0, 1'b0, 7, 31, 15, 30);
    pcase(1'b0, 1'b1, 2, 4, 31, 31);
    hcmd(8'h08);
    pulse(rx);
    idle(3);
    `CHK(irq_seen, 1'b1)
    hcmd(8'h40);
    idle(3);
    `CHK(irq_seen, 1'b0)
    hcmd(8'h80);
    hcmd(8'h01);
    final_report;
  end

  // Whole run needs well under 2000 cycles
  initial
  begin
    repeat (5000) @(posedge sys_clk);
    error_cnt++;
    final_report;
  end
endmodule
